// [mscu_core.sv]
// Upper machine state word with exception entry, return and gating logic
`timescale 1ns/1ps
`default_nettype none
module mscu_core
   import mscu_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire mscu_cmd_e   cmd,
   input  wire logic [31:0] cmd_data,
   input  wire mscu_exc_s   exc,
   input  wire logic        ext_irq_req,
   input  wire logic        smi_req,
   input  wire logic        dec_req,
   input  wire logic        mcheck_req,
   input  wire logic        crit_req,
   input  wire logic        instr_done,
   input  wire logic        instr_is_branch,
   input  wire logic        instr_is_super,
   input  wire logic        instr_is_float,
   input  wire mscu_rd_e    rd_sel,
   input  wire logic        rd_strobe,
   output logic [31:0]      rd_data,
   output logic             rd_valid,
   output mscu_ctrl_s       ctrl,
   output logic             ext_irq_take,
   output logic             smi_take,
   output logic             dec_take,
   output logic             mcheck_take,
   output logic             crit_take,
   output logic             priv_fault,
   output logic             float_unavail,
   output logic             trace_trap,
   output logic [31:0]      vector_addr,
   output logic [31:0]      return_addr,
   output logic             return_valid
);

   // ****************************************
   // Word storage (bits 15..31, big-endian numbering)
   // ****************************************
   logic [16:0] upper;
   logic [16:0] next_upper;
   logic [31:0] word;
   logic [31:0] ord_addr;
   logic [31:0] ord_state;
   logic [31:0] crit_addr;
   logic [31:0] crit_state;
   logic        ord_save;
   logic        crit_save;

   // Word bit n (0 = MSB) sits at vector index 31-n
   function automatic logic wbit(input logic [31:0] w, input int unsigned n);
      return w[31-n];
   endfunction

   assign word = {15'h0000, upper};

   assign ord_save  = exc.take & ~exc.critical;
   assign crit_save = exc.take & exc.critical;

   // ****************************************
   // Save/restore pairs
   // ****************************************
   mscu_save_pair #(.WIDTH(32)) u_ord_pair (
      .clk      (clk),
      .reset    (reset),
      .save     (ord_save),
      .addr_in  (exc.resume_addr),
      .state_in (word),
      .addr_q   (ord_addr),
      .state_q  (ord_state)
   );

   mscu_save_pair #(.WIDTH(32)) u_crit_pair (
      .clk      (clk),
      .reset    (reset),
      .save     (crit_save),
      .addr_in  (exc.resume_addr),
      .state_in (word),
      .addr_q   (crit_addr),
      .state_q  (crit_state)
   );

   // ****************************************
   // Word update
   // ****************************************
   // Entry wins over an instruction write in the same cycle: the
   // instruction is being abandoned by the exception.
   always_comb begin
      next_upper = upper;
      if (exc.take) begin
         // Other bits keep value; only byte order follows entry mode
         next_upper[31-BYTE_ORDER_BIT] = upper[31-EXC_BYTE_ORDER_BIT];
      end else begin
         case (cmd)
            MSCU_CMD_MOVE_TO,
            MSCU_CMD_SYSCALL:  next_upper = cmd_data[16:0];
            MSCU_CMD_RET_EXC:  next_upper = ord_state[16:0];
            MSCU_CMD_RET_CRIT: begin
               if (upper[31-CRIT_GATE_BIT]) begin
                  next_upper = crit_state[16:0];
               end
            end
            default:           next_upper = upper;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         upper <= UPPER_RESET;
      end else begin
         upper <= next_upper;
      end
   end

   // ****************************************
   // Return path
   // ****************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         return_addr  <= 32'h00000000;
         return_valid <= 1'b0;
      end else begin
         return_valid <= 1'b0;
         if (!exc.take && cmd == MSCU_CMD_RET_EXC) begin
            return_addr  <= ord_addr;
            return_valid <= 1'b1;
         end else if (!exc.take && cmd == MSCU_CMD_RET_CRIT && upper[31-CRIT_GATE_BIT]) begin
            return_addr  <= crit_addr;
            return_valid <= 1'b1;
         end
      end
   end

   // ****************************************
   // Read port: only move-from reaches the word
   // ****************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data  <= 32'h00000000;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_strobe;
         if (rd_strobe) begin
            case (rd_sel)
               MSCU_RD_WORD:  rd_data <= word;
               MSCU_RD_SADDR: rd_data <= crit_addr;
               MSCU_RD_SSTAT: rd_data <= crit_state;
               default:       rd_data <= 32'h00000000;
            endcase
         end
      end
   end

   // ****************************************
   // Named word bits
   // ****************************************
   logic outside_irq_gate;
   logic user_only_level;
   logic float_unit_avail;
   logic machine_check_gate;
   logic float_trap_mode_low;
   logic single_step_trace;
   logic branch_trace;
   logic float_trap_mode_high;
   logic crit_irq_gate;
   logic vector_high_base;
   logic fetch_translation_on;
   logic load_store_translation_on;
   logic recoverable_flag;
   logic byte_order_mode;

   assign outside_irq_gate          = wbit(word, OUTSIDE_IRQ_BIT);
   assign user_only_level           = wbit(word, USER_ONLY_BIT);
   assign float_unit_avail          = wbit(word, FLOAT_AVAIL_BIT);
   assign machine_check_gate        = wbit(word, MCHECK_GATE_BIT);
   assign float_trap_mode_low       = wbit(word, FTRAP_LOW_BIT);
   assign single_step_trace         = wbit(word, SINGLE_STEP_BIT);
   assign branch_trace              = wbit(word, BRANCH_TRACE_BIT);
   assign float_trap_mode_high      = wbit(word, FTRAP_HIGH_BIT);
   assign crit_irq_gate             = wbit(word, CRIT_GATE_BIT);
   assign vector_high_base          = wbit(word, VEC_HIGH_BIT);
   assign fetch_translation_on      = wbit(word, FETCH_XLAT_BIT);
   assign load_store_translation_on = wbit(word, LS_XLAT_BIT);
   assign recoverable_flag          = wbit(word, RECOVERABLE_BIT);
   assign byte_order_mode           = wbit(word, BYTE_ORDER_BIT);

   // ****************************************
   // Decoded controls
   // ****************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl <= '0;
      end else begin
         ctrl.irq_allow                 <= outside_irq_gate;
         ctrl.supervisor_ok             <= ~user_only_level;
         ctrl.float_dispatch_ok         <= float_unit_avail;
         ctrl.mcheck_allow              <= machine_check_gate;
         ctrl.float_trap_mode           <= {float_trap_mode_high,
                                            float_trap_mode_low};
         ctrl.crit_allow                <= crit_irq_gate;
         ctrl.fetch_translation_on      <= fetch_translation_on;
         ctrl.load_store_translation_on <= load_store_translation_on;
         ctrl.recoverable_flag          <= recoverable_flag;
         ctrl.little_endian             <= byte_order_mode;
      end
   end

   // ****************************************
   // Interrupt gating
   // ****************************************
   // One block per request, so each gate stands alone in timing
   always_ff @(posedge clk) begin
      if (reset) begin
         ext_irq_take <= 1'b0;
      end else begin
         ext_irq_take <= ext_irq_req & outside_irq_gate;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         smi_take <= 1'b0;
      end else begin
         smi_take <= smi_req & outside_irq_gate;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         dec_take <= 1'b0;
      end else begin
         dec_take <= dec_req & outside_irq_gate;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mcheck_take <= 1'b0;
      end else begin
         mcheck_take <= mcheck_req & machine_check_gate;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         crit_take <= 1'b0;
      end else begin
         crit_take <= crit_req & crit_irq_gate;
      end
   end

   // ****************************************
   // Instruction checks and trace
   // ****************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         priv_fault <= 1'b0;
      end else begin
         priv_fault <= instr_is_super & user_only_level;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         float_unavail <= 1'b0;
      end else begin
         float_unavail <= instr_is_float & ~float_unit_avail;
      end
   end

   // Only completed instructions trap; squashed ones never report
   always_ff @(posedge clk) begin
      if (reset) begin
         trace_trap <= 1'b0;
      end else begin
         trace_trap <= instr_done & (single_step_trace
                       | (instr_is_branch & branch_trace));
      end
   end

   // ****************************************
   // Vector address
   // ****************************************
   // Critical entries always use the fixed critical offset
   always_ff @(posedge clk) begin
      if (reset) begin
         vector_addr <= 32'h00000000;
      end else if (exc.take) begin
         vector_addr <= {vector_high_base ? VEC_BASE_HIGH : VEC_BASE_LOW,
                         exc.critical ? CRIT_VEC_OFFSET : exc.offset};
      end
   end

endmodule
`default_nettype wire

// [mscu_pkg.sv]
// Package for the machine state control upper block: bit positions, vectors, commands
package mscu_pkg;

   // ****************************************
   // Bit positions (bit 0 is the word's MSB)
   // ****************************************
   localparam int unsigned EXC_BYTE_ORDER_BIT = 15;
   localparam int unsigned OUTSIDE_IRQ_BIT    = 16;
   localparam int unsigned USER_ONLY_BIT      = 17;
   localparam int unsigned FLOAT_AVAIL_BIT    = 18;
   localparam int unsigned MCHECK_GATE_BIT    = 19;
   localparam int unsigned FTRAP_LOW_BIT      = 20;
   localparam int unsigned SINGLE_STEP_BIT    = 21;
   localparam int unsigned BRANCH_TRACE_BIT   = 22;
   localparam int unsigned FTRAP_HIGH_BIT     = 23;
   localparam int unsigned CRIT_GATE_BIT      = 24;
   localparam int unsigned VEC_HIGH_BIT       = 25;
   localparam int unsigned FETCH_XLAT_BIT     = 26;
   localparam int unsigned LS_XLAT_BIT        = 27;
   localparam int unsigned RSVD_A_BIT         = 28;
   localparam int unsigned RSVD_B_BIT         = 29;
   localparam int unsigned RECOVERABLE_BIT    = 30;
   localparam int unsigned BYTE_ORDER_BIT     = 31;

   // ****************************************
   // Reset values and vector constants
   // ****************************************
   localparam logic [16:0] UPPER_RESET     = 17'h00000;
   localparam logic [11:0] VEC_BASE_LOW    = 12'h000;
   localparam logic [11:0] VEC_BASE_HIGH   = 12'hFFF;
   localparam logic [19:0] CRIT_VEC_OFFSET = 20'h00A00;
   localparam logic [31:0] SAVE_RESET      = 32'h00000000;

   // ****************************************
   // Word update commands from the pipeline
   // ****************************************
   typedef enum logic [2:0] {
      MSCU_CMD_NONE     = 3'b000,
      MSCU_CMD_MOVE_TO  = 3'b001,
      MSCU_CMD_SYSCALL  = 3'b010,
      MSCU_CMD_RET_EXC  = 3'b011,
      MSCU_CMD_RET_CRIT = 3'b100
   } mscu_cmd_e;

   // Decoded controls handed out by the core
   typedef struct packed {
      logic       irq_allow;
      logic       supervisor_ok;
      logic       float_dispatch_ok;
      logic       mcheck_allow;
      logic [1:0] float_trap_mode;
      logic       crit_allow;
      logic       fetch_translation_on;
      logic       load_store_translation_on;
      logic       recoverable_flag;
      logic       little_endian;
   } mscu_ctrl_s;

   // Exception request from the sequencer
   typedef struct packed {
      logic        take;
      logic        critical;
      logic [19:0] offset;
      logic [31:0] resume_addr;
   } mscu_exc_s;

   // Read selection for move-from and save-register reads
   typedef enum logic [1:0] {
      MSCU_RD_WORD  = 2'b00,
      MSCU_RD_SADDR = 2'b01,
      MSCU_RD_SSTAT = 2'b10
   } mscu_rd_e;

endpackage

// [mscu_save_pair.sv]
// Save/restore register pair for exception entry and return
`timescale 1ns/1ps
`default_nettype none
module mscu_save_pair
   import mscu_pkg::*;
#(
   parameter int unsigned WIDTH = 32
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             save,
   input  wire logic [WIDTH-1:0] addr_in,
   input  wire logic [WIDTH-1:0] state_in,
   output logic      [WIDTH-1:0] addr_q,
   output logic      [WIDTH-1:0] state_q
);

   always_ff @(posedge clk) begin
      if (reset) begin
         addr_q  <= WIDTH'(SAVE_RESET);
         state_q <= WIDTH'(SAVE_RESET);
      end else if (save) begin
         addr_q  <= addr_in;
         state_q <= state_in;
      end
   end

endmodule
`default_nettype wire

// [mscu_core_checker.sv]
// Port-level assertions for the machine state control upper block
`timescale 1ns/1ps
`default_nettype none
module mscu_core_checker
   import mscu_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire mscu_cmd_e   cmd,
   input wire mscu_exc_s   exc,
   input wire logic        ext_irq_req,
   input wire logic        mcheck_req,
   input wire logic        crit_req,
   input wire logic        instr_done,
   input wire logic        instr_is_super,
   input wire logic        rd_strobe,
   input wire logic        rd_valid,
   input wire logic        ext_irq_take,
   input wire logic        mcheck_take,
   input wire logic        crit_take,
   input wire logic        priv_fault,
   input wire logic        trace_trap,
   input wire logic [31:0] vector_addr,
   input wire logic        return_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   ext_take_a: assert property (ext_irq_take |-> $past(ext_irq_req))
      else $error("external take without request");
   mcheck_take_a: assert property (mcheck_take |-> $past(mcheck_req))
      else $error("machine check take without request");
   crit_take_a: assert property (crit_take |-> $past(crit_req))
      else $error("critical take without request");
   priv_cause_a: assert property (priv_fault |-> $past(instr_is_super))
      else $error("privilege fault without supervisor instruction");
   trace_cause_a: assert property (trace_trap |-> $past(instr_done))
      else $error("trace trap without completion");
   read_answer_a: assert property (rd_valid == $past(rd_strobe))
      else $error("read answer not one cycle after strobe");
   crit_vector_a: assert property (exc.take && exc.critical |=> vector_addr[19:0] == CRIT_VEC_OFFSET
      && (vector_addr[31:20] == VEC_BASE_HIGH || vector_addr[31:20] == VEC_BASE_LOW)) else $error("bad critical vector");
   return_cause_a: assert property (return_valid |-> $past(cmd) inside {MSCU_CMD_RET_EXC, MSCU_CMD_RET_CRIT}
      && !$past(exc.take)) else $error("return without return command");
   cover property (exc.take && exc.critical);
   cover property (return_valid);
   cover property (ext_irq_take);
endmodule
bind mscu_core mscu_core_checker chk_i (.clk(clk), .reset(reset), .cmd(cmd), .exc(exc),
   .ext_irq_req(ext_irq_req), .mcheck_req(mcheck_req), .crit_req(crit_req), .instr_done(instr_done),
   .instr_is_super(instr_is_super), .rd_strobe(rd_strobe), .rd_valid(rd_valid), .ext_irq_take(ext_irq_take),
   .mcheck_take(mcheck_take), .crit_take(crit_take), .priv_fault(priv_fault), .trace_trap(trace_trap),
   .vector_addr(vector_addr), .return_valid(return_valid));
`default_nettype wire

// [mscu_seq_model.sv]
// Exception sequencer model turning granted external and critical requests into exception entries
`timescale 1ns/1ps
`default_nettype none
module mscu_seq_model
   import mscu_pkg::*;
#(
   parameter logic [31:0] RESUME = 32'h00001230,
   parameter logic [19:0] OFFS   = 20'h00500
) (
   input  wire logic      clk,
   input  wire logic      reset,
   input  wire logic      ext_irq_take,
   input  wire logic      crit_take,
   output var  mscu_exc_s exc
);
   // Critical wins a tie, since it owns a separate save pair
   always_ff @(posedge clk) begin
      if (reset) begin
         exc <= '0;
      end else begin
         exc.take        <= ext_irq_take | crit_take;
         exc.critical    <= crit_take;
         exc.offset      <= crit_take ? CRIT_VEC_OFFSET : OFFS;
         exc.resume_addr <= RESUME;
      end
   end
endmodule
`default_nettype wire

// [tb_machine_state_control_upper.sv]
// Self-checking bench for the machine state control upper block
`timescale 1ns/1ps
`default_nettype none
module tb_machine_state_control_upper;
   import mscu_pkg::*;
   localparam logic [31:0] RA   = 32'h00001230;
   localparam logic [19:0] OFFS = 20'h00500;
   logic        clk = 0, reset = 1, rd_strobe = 0, rd_valid, return_valid;
   mscu_cmd_e   cmd = MSCU_CMD_NONE;
   mscu_rd_e    rd_sel = MSCU_RD_WORD;
   logic [31:0] cmd_data = '0, rd_data, vector_addr, return_addr, v;
   logic [8:0]  req = '0;
   logic [7:0]  tk;
   mscu_exc_s   exc;
   mscu_ctrl_s  ctrl;
   int          error_cnt = 0, num_checks = 0;
   mscu_core dut (.clk(clk), .reset(reset), .cmd(cmd), .cmd_data(cmd_data), .exc(exc),
      .ext_irq_req(req[8]), .smi_req(req[7]), .dec_req(req[6]), .mcheck_req(req[5]), .crit_req(req[4]),
      .instr_done(req[3]), .instr_is_branch(req[2]), .instr_is_super(req[1]), .instr_is_float(req[0]),
      .rd_sel(rd_sel), .rd_strobe(rd_strobe), .rd_data(rd_data), .rd_valid(rd_valid), .ctrl(ctrl),
      .ext_irq_take(tk[7]), .smi_take(tk[6]), .dec_take(tk[5]), .mcheck_take(tk[4]), .crit_take(tk[3]),
      .priv_fault(tk[2]), .float_unavail(tk[1]), .trace_trap(tk[0]), .vector_addr(vector_addr),
      .return_addr(return_addr), .return_valid(return_valid));
   mscu_seq_model #(.RESUME(RA), .OFFS(OFFS)) model (.clk(clk), .reset(reset), .ext_irq_take(tk[7]),
      .crit_take(tk[3]), .exc(exc));
   always #2.5 clk = ~clk;
   function automatic logic [31:0] m(int n);
      return 32'h1 << (31 - n);
   endfunction
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   // Command held for one edge; cmd goes back to none with no idle edge after it
   task automatic put(mscu_cmd_e c, logic [31:0] d);
      cmd = c;
      cmd_data = d;
      tick;
      cmd = MSCU_CMD_NONE;
   endtask
   task automatic get(mscu_rd_e s, output logic [31:0] d);
      rd_sel = s;
      rd_strobe = 1;
      tick;
      rd_strobe = 0;
      chk("rd_valid", {31'h0, rd_valid}, 32'h1);
      d = rd_data;
      tick;
   endtask
   task automatic fire(logic [8:0] r, logic [7:0] e);
      req = r;
      tick;
      req = '0;
      chk("takes", {24'h0, tk}, {24'h0, e});
      // A granted entry lands two edges on; a command then would be dropped
      repeat (2) tick;
   endtask
   task automatic t_rw;
      get(MSCU_RD_WORD, v);
      chk("reset word", v, 32'h0);
      put(MSCU_CMD_MOVE_TO, 32'hFFFFFFFF);
      tick;
      get(MSCU_RD_WORD, v);
      chk("word ones", v, 32'h0001FFFF);
      chk("ctrl ones", {21'h0, ctrl}, 32'h000005FF);
      put(MSCU_CMD_MOVE_TO, 32'h0);
      tick;
      get(MSCU_RD_WORD, v);
      chk("ctrl zero", {21'h0, ctrl}, 32'h00000200);
   endtask
   task automatic t_gates;
      put(MSCU_CMD_MOVE_TO, m(16) | m(17) | m(18) | m(19) | m(21) | m(24));
      tick;
      fire(9'h1FF, 8'hFD);
      put(MSCU_CMD_MOVE_TO, 32'h0);
      tick;
      fire(9'h1FF, 8'h02);
      put(MSCU_CMD_MOVE_TO, m(22));
      tick;
      fire(9'h008, 8'h00);
      fire(9'h00C, 8'h01);
   endtask
   task automatic t_crit;
      put(MSCU_CMD_MOVE_TO, m(15) | m(24) | m(25) | m(30));
      tick;
      fire(9'h010, 8'h08);
      tick;
      chk("crit vector", vector_addr, {VEC_BASE_HIGH, CRIT_VEC_OFFSET});
      get(MSCU_RD_WORD, v);
      chk("entry word", v, m(15) | m(24) | m(25) | m(30) | m(31));
      get(MSCU_RD_SADDR, v);
      chk("crit addr", v, RA);
      get(MSCU_RD_SSTAT, v);
      chk("crit state", v, m(15) | m(24) | m(25) | m(30));
      put(MSCU_CMD_RET_CRIT, 32'h0);
      chk("crit return", {return_valid, return_addr[30:0]}, {1'b1, RA[30:0]});
      get(MSCU_RD_WORD, v);
      chk("crit restored", v, m(15) | m(24) | m(25) | m(30));
      put(MSCU_CMD_MOVE_TO, 32'h0);
      tick;
      put(MSCU_CMD_RET_CRIT, 32'h0);
      chk("gated return", {31'h0, return_valid}, 32'h0);
   endtask
   task automatic t_ext;
      put(MSCU_CMD_SYSCALL, m(16) | m(31));
      tick;
      fire(9'h100, 8'h80);
      tick;
      chk("ext vector", vector_addr, {VEC_BASE_LOW, OFFS});
      get(MSCU_RD_WORD, v);
      chk("ext entry word", v, m(16));
      put(MSCU_CMD_RET_EXC, 32'h0);
      chk("ext return", {return_valid, return_addr[30:0]}, {1'b1, RA[30:0]});
      get(MSCU_RD_WORD, v);
      chk("ext restored", v, m(16) | m(31));
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #5000;
      error_cnt++;
      give_verdict;
   end
   initial begin
      repeat (3) tick;
      reset = 0;
      t_rw;
      t_gates;
      t_crit;
      t_ext;
      give_verdict;
   end
endmodule
`default_nettype wire
